// File: src/ptc_core.sv
// Purpose: Counter core of one PWM timer channel with prescaler and registers.
// Assumes: Source clocks arrive asynchronously and are far slower than clock.
// Notes:   Compare, capture, waveform outputs and interrupts live elsewhere.
//
// Summary of operation
// RL1: The selected source is divided by 1/1 up to 1/16384 by a 4-bit code, 0xf is reserved, and the slow oscillator stops at 1/256.
// RL2: A 2-bit source field picks internal oscillator (0x0), the two other oscillators, or the external clock (0x3).
// RL3: On channel 0 only, clock control bit D1 selects multi-compare mode, elsewhere it reads zero.
// RL4: The divided clock reaches the counter only while the count clock gate bit is 1, which resets to 0.
// RL5: On the supporting variant bit D6 of the counter control enables half rate mode, else it is reserved.
// RL6: A 2-bit field selects which counter channel 0 to 3 the compare and capture circuits use.
// RL7: The compare buffer enable bit chooses buffered or direct compare values and resets to 0.
// RL8: The count mode bit selects one-shot when 1 and repeat when 0, repeat after reset.
// RL9: Writing 1 to counter reset clears the counter, writing 0 does nothing, and one variant reads it as 0.
// RL10: On the other variant the counter reset bit reads 1 while the reset is in progress.
// RL11: The counter counts while run is 1 and holds while 0, the bit being read-write and reset to 0.
// RL12: The 16-bit count is readable, read-only, resets to zero and ignores writes.
// RL13: Running with the clock gated on, the counter advances once per tick, one-shot stops after a full period.
`timescale 1ns/10ps
module ptc_core #(
	parameter int CHANNEL      = 0,  // Channel number of this instance
	parameter bit HALF_VARIANT = 1'b0 // Half rate mode and reset status present
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Register port
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	// Source clocks, asynchronous
	input  wire logic        internal_osc,
	input  wire logic        low_speed_osc,
	input  wire logic        high_speed_osc,
	input  wire logic        external_clk,
	// Towards compare and capture logic
	output logic      [15:0] count_value,
	output logic             count_tick,
	output logic      [1:0]  compare_counter_sel,
	output logic             compare_buffer_on,
	output logic             multi_compare_mode,
	output logic             half_rate_mode,
	output logic             counter_running
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ptc_pkg::ptc_state_t state_q;
	ptc_pkg::ptc_state_t state_d;

	// Combinational helpers
	logic [3:0]  src_rise;
	logic        sel_rise;
	logic        ratio_ok;
	logic [13:0] ratio_mask;
	logic        div_tick;
	logic        adv_tick;
	logic        wr_clk;
	logic        wr_ctl;
	logic [15:0] clk_view;
	logic [15:0] ctl_view;

	// ------------------------------------------------------------
	// Register read views
	// ------------------------------------------------------------
	always_comb begin
		clk_view = 16'h0000;
		clk_view[ptc_pkg::CLK_RATIO_LSB +: 4]  = state_q.regs.prescale_ratio_sel;
		clk_view[ptc_pkg::CLK_SOURCE_LSB +: 2] = state_q.regs.count_source_sel;
		clk_view[ptc_pkg::CLK_MULTI_BIT]       = state_q.regs.multi_compare_mode; // RL3
		clk_view[ptc_pkg::CLK_GATE_BIT]        = state_q.regs.count_clock_gate;
		ctl_view = 16'h0000;
		ctl_view[ptc_pkg::CTL_HALF_BIT]        = state_q.regs.half_rate_mode;
		ctl_view[ptc_pkg::CTL_CSEL_LSB +: 2]   = state_q.regs.compare_counter_sel;
		ctl_view[ptc_pkg::CTL_BUF_BIT]         = state_q.regs.compare_buffer_on;
		ctl_view[ptc_pkg::CTL_MODE_BIT]        = state_q.regs.oneshot_repeat_sel;
		// Status read only where the variant has it; else always zero
		ctl_view[ptc_pkg::CTL_RESET_BIT]       = HALF_VARIANT & state_q.reset_busy; // RL9 RL10
		ctl_view[ptc_pkg::CTL_RUN_BIT]         = state_q.regs.counter_run;
	end

	// ------------------------------------------------------------
	// Source select and prescaler
	// ------------------------------------------------------------
	always_comb begin
		// Edges come from the second stage only; the first is never looked at
		src_rise = state_q.sync_b & ~state_q.sync_prev;
		case (state_q.regs.count_source_sel)  // RL2
			ptc_pkg::SRC_INTERNAL_OSC:   sel_rise = src_rise[0];
			ptc_pkg::SRC_LOW_SPEED_OSC:  sel_rise = src_rise[1];
			ptc_pkg::SRC_HIGH_SPEED_OSC: sel_rise = src_rise[2];
			ptc_pkg::SRC_EXTERNAL:       sel_rise = src_rise[3];
			default:                     sel_rise = 1'b0;
		endcase
		// Reserved codes give no tick at all, so the counter simply holds
		if (state_q.regs.count_source_sel == ptc_pkg::SRC_LOW_SPEED_OSC) begin
			ratio_ok = state_q.regs.prescale_ratio_sel <= ptc_pkg::RATIO_LAST_LOW_OSC; // RL1
		end else begin
			ratio_ok = state_q.regs.prescale_ratio_sel <= ptc_pkg::RATIO_LAST_CODE; // RL1
		end
		ratio_mask = 14'(({14'h0000, 14'h0001} << state_q.regs.prescale_ratio_sel) - 28'h1);
		div_tick   = state_q.regs.count_clock_gate & ratio_ok & sel_rise // RL4
			& ((state_q.prescale & ratio_mask) == ratio_mask);          // RL1
		// Half rate mode passes every second divided tick
		adv_tick   = div_tick & (~state_q.regs.half_rate_mode | state_q.half_phase); // RL5
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign wr_clk = wr & (addr == ptc_pkg::ADDR_TIMER_CLOCK_CONTROL);
	assign wr_ctl = wr & (addr == ptc_pkg::ADDR_TIMER_COUNTER_CONTROL);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;

		// Two-flop synchronisers, then the edge history
		state_d.sync_a    = {external_clk, high_speed_osc, low_speed_osc, internal_osc};
		state_d.sync_b    = state_q.sync_a;
		state_d.sync_prev = state_q.sync_b;

		// Prescaler only moves on source edges while the gate is open
		if (!state_q.regs.count_clock_gate) begin
			state_d.prescale   = ptc_pkg::PRESCALE_RESET; // RL4
			state_d.half_phase = 1'b0;
		end else if (sel_rise) begin
			state_d.prescale = 14'(state_q.prescale + 14'h0001); // RL1
		end
		if (div_tick) begin
			state_d.half_phase = ~state_q.half_phase;
		end

		// Clock control writes
		if (wr_clk) begin
			state_d.regs.prescale_ratio_sel = wdata[ptc_pkg::CLK_RATIO_LSB +: 4];  // RL1
			state_d.regs.count_source_sel   = wdata[ptc_pkg::CLK_SOURCE_LSB +: 2]; // RL2
			state_d.regs.multi_compare_mode =
				(CHANNEL == 0) & wdata[ptc_pkg::CLK_MULTI_BIT];               // RL3
			state_d.regs.count_clock_gate   = wdata[ptc_pkg::CLK_GATE_BIT];       // RL4
		end

		// Counter advance; one-shot stops at the end of a full period
		state_d.count_tick = 1'b0;
		if (state_q.regs.counter_run && adv_tick) begin                  // RL11
			state_d.count_value = 16'(state_q.count_value + 16'h0001);  // RL13
			state_d.count_tick  = 1'b1;
			if (state_q.regs.oneshot_repeat_sel
				&& state_q.count_value == ptc_pkg::COUNT_LAST_VALUE) begin
				state_d.regs.counter_run = 1'b0;                         // RL8 RL13
			end
		end

		// A pending reset clears the counter one cycle after the write
		if (state_q.reset_busy) begin
			state_d.count_value = ptc_pkg::COUNT_RESET_VALUE;           // RL9
			state_d.count_tick  = 1'b0; // An overridden advance shows no tick
			state_d.reset_busy  = 1'b0;                                 // RL10
		end

		// Counter control writes; a software run write beats the one-shot stop
		if (wr_ctl) begin
			state_d.regs.half_rate_mode =
				HALF_VARIANT & wdata[ptc_pkg::CTL_HALF_BIT];            // RL5
			state_d.regs.compare_counter_sel = wdata[ptc_pkg::CTL_CSEL_LSB +: 2]; // RL6
			state_d.regs.compare_buffer_on   = wdata[ptc_pkg::CTL_BUF_BIT];       // RL7
			state_d.regs.oneshot_repeat_sel  = wdata[ptc_pkg::CTL_MODE_BIT];      // RL8
			state_d.regs.counter_run         = wdata[ptc_pkg::CTL_RUN_BIT];       // RL11
			if (wdata[ptc_pkg::CTL_RESET_BIT]) begin
				state_d.reset_busy = 1'b1;                              // RL9 RL10
			end
		end

		// Read data stand only in the cycle after the strobe
		state_d.rdata = 16'h0000;
		if (rd) begin
			case (addr)
				ptc_pkg::ADDR_TIMER_CLOCK_CONTROL:   state_d.rdata = clk_view;
				ptc_pkg::ADDR_TIMER_COUNTER_CONTROL: state_d.rdata = ctl_view;
				ptc_pkg::ADDR_TIMER_COUNT_VALUE:     state_d.rdata = state_q.count_value; // RL12
				default:                             state_d.rdata = 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= '0; // All fields reset to zero, repeat mode, gate off
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------
	assign rdata               = state_q.rdata;
	assign count_value         = state_q.count_value; // RL12
	assign count_tick          = state_q.count_tick;
	assign compare_counter_sel = state_q.regs.compare_counter_sel; // RL6
	assign compare_buffer_on   = state_q.regs.compare_buffer_on;   // RL7
	assign multi_compare_mode  = state_q.regs.multi_compare_mode;
	assign half_rate_mode      = state_q.regs.half_rate_mode;
	assign counter_running     = state_q.regs.counter_run;

endmodule : ptc_core

// File: src/ptc_pkg.sv
// Purpose: Constants and types shared by the PWM timer counter core.
// Assumes: 16-bit register port; registers at their printed addresses.
// Notes:   Every address, field position, code and reset value used by the core is named here once.
package ptc_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_TIMER_COUNTER_CONTROL = 16'h5400;
	localparam logic [15:0] ADDR_TIMER_COUNT_VALUE     = 16'h5402;
	localparam logic [15:0] ADDR_TIMER_CLOCK_CONTROL   = 16'h5068;

	// ------------------------------------------------------------
	// Clock control field positions
	// ------------------------------------------------------------
	localparam int CLK_RATIO_LSB   = 4;
	localparam int CLK_SOURCE_LSB  = 2;
	localparam int CLK_MULTI_BIT   = 1;
	localparam int CLK_GATE_BIT    = 0;

	// ------------------------------------------------------------
	// Counter control field positions
	// ------------------------------------------------------------
	localparam int CTL_HALF_BIT    = 6;
	localparam int CTL_CSEL_LSB    = 4;
	localparam int CTL_BUF_BIT     = 3;
	localparam int CTL_MODE_BIT    = 2;
	localparam int CTL_RESET_BIT   = 1;
	localparam int CTL_RUN_BIT     = 0;

	// ------------------------------------------------------------
	// Codes and reset values
	// ------------------------------------------------------------
	localparam logic [3:0]  RATIO_LAST_CODE    = 4'he;
	localparam logic [3:0]  RATIO_LAST_LOW_OSC = 4'h8;
	localparam logic [1:0]  SRC_INTERNAL_OSC   = 2'h0;
	localparam logic [1:0]  SRC_LOW_SPEED_OSC  = 2'h1;
	localparam logic [1:0]  SRC_HIGH_SPEED_OSC = 2'h2;
	localparam logic [1:0]  SRC_EXTERNAL       = 2'h3;
	localparam logic [15:0] COUNT_RESET_VALUE  = 16'h0000;
	localparam logic [15:0] COUNT_LAST_VALUE   = 16'hffff;
	localparam logic [13:0] PRESCALE_RESET     = 14'h0000;

	// ------------------------------------------------------------
	// Software visible settings
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] prescale_ratio_sel;
		logic [1:0] count_source_sel;
		logic       multi_compare_mode;
		logic       count_clock_gate;
		logic       half_rate_mode;
		logic [1:0] compare_counter_sel;
		logic       compare_buffer_on;
		logic       oneshot_repeat_sel;
		logic       counter_run;
	} ptc_regs_t;

	// ------------------------------------------------------------
	// Whole core state
	// ------------------------------------------------------------
	typedef struct packed {
		ptc_regs_t   regs;
		logic [3:0]  sync_a;      // First synchroniser stage per source
		logic [3:0]  sync_b;      // Second synchroniser stage per source
		logic [3:0]  sync_prev;   // Previous level, for edge detection
		logic [13:0] prescale;
		logic        half_phase;
		logic        reset_busy;
		logic [15:0] count_value;
		logic        count_tick;
		logic [15:0] rdata;
	} ptc_state_t;

endpackage : ptc_pkg

// File: tb/ptc_core_chk.sv
// Purpose: Port-level assertions for the timer counter core.
// Assumes: Channel number and variant are handed in by the bind.
// Notes:   Bound to the core from the testbench top file.
`timescale 1ns/10ps
module ptc_core_chk #(
	parameter int CHANNEL      = 0,   // Channel number of the bound core
	parameter bit HALF_VARIANT = 1'b0 // Half rate variant of the bound core
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// Register port
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	// Core outputs
	input wire logic [15:0] count_value,
	input wire logic        count_tick,
	input wire logic [1:0]  compare_counter_sel,
	input wire logic        compare_buffer_on,
	input wire logic        multi_compare_mode,
	input wire logic        half_rate_mode,
	input wire logic        counter_running
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Control writes land in the outputs one edge later
	logic ctl_wr;
	assign ctl_wr = wr && addr == ptc_pkg::ADDR_TIMER_COUNTER_CONTROL;
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data not zero outside read answer");
	a_tick_advances: assert property (
		count_tick |-> count_value == 16'($past(count_value) + 16'h0001))
		else $error("tick without an advance by one");
	// A counter reset written a cycle earlier may still clear a stopped counter
	a_stop_holds: assert property (
		!counter_running && !wr && !$past(ctl_wr && wdata[1]) |=> $stable(count_value))
		else $error("counter moved while stopped");
	a_stop_no_tick: assert property (!counter_running && !wr |=> !count_tick)
		else $error("tick while stopped");
	a_run_write: assert property (ctl_wr |=> counter_running == $past(wdata[0]))
		else $error("run bit not taken");
	a_sel_buf_write: assert property (
		ctl_wr |=> compare_counter_sel == $past(wdata[5:4])
			&& compare_buffer_on == $past(wdata[3]))
		else $error("select or buffer bit not taken");
	a_reset_clears: assert property (ctl_wr && wdata[1] |-> ##[1:2] count_value == 16'h0000)
		else $error("counter reset did not clear");
	// Only channel 0 keeps the multi mode bit
	a_multi_write: assert property (
		wr && addr == ptc_pkg::ADDR_TIMER_CLOCK_CONTROL
			|=> multi_compare_mode == ((CHANNEL == 0) && $past(wdata[1])))
		else $error("multi mode bit not taken");
	// Only the half rate variant keeps the half rate bit
	a_half_write: assert property (
		ctl_wr |=> half_rate_mode == (HALF_VARIANT && $past(wdata[6])))
		else $error("half rate bit wrong for the variant");
	// Main scenarios
	c_tick: cover property (count_tick);
	c_count_read: cover property (rd && addr == ptc_pkg::ADDR_TIMER_COUNT_VALUE);
	c_reset: cover property (ctl_wr && wdata[1]);
	c_half_tick: cover property (half_rate_mode && count_tick);
endmodule : ptc_core_chk

// File: tb/ptc_core_test.sv
// Purpose: Self-checking register and counting tests of the core.
// Assumes: Sources are slow pulses made here, idle low between runs.
// Notes:   One-shot wrap needs 65536 ticks and is left out for run time.
`timescale 1ns/10ps
module ptc_core_test;
	logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, count_value;
	logic [3:0] src_clk = 4'h0; // Sources in select-code order
	logic [1:0] sel;
	logic tick, buf_on, multi, half, running;
	logic [15:0] rdata_hv, count_hv;
	logic half_hv, multi_hv;
	int failures = 0, n_tests = 0;
	localparam logic [15:0] CTL = ptc_pkg::ADDR_TIMER_COUNTER_CONTROL;
	localparam logic [15:0] TC = ptc_pkg::ADDR_TIMER_COUNT_VALUE;
	localparam logic [15:0] CLK = ptc_pkg::ADDR_TIMER_CLOCK_CONTROL;
	// 125 MHz clock
	always #4 clock = ~clock;
	ptc_core dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .internal_osc(src_clk[0]), .low_speed_osc(src_clk[1]),
		.high_speed_osc(src_clk[2]), .external_clk(src_clk[3]), .count_value(count_value),
		.count_tick(tick), .compare_counter_sel(sel), .compare_buffer_on(buf_on),
		.multi_compare_mode(multi), .half_rate_mode(half), .counter_running(running));
	// Second channel with the half rate variant, on the same register port
	ptc_core #(.CHANNEL(1), .HALF_VARIANT(1'b1)) dut_hv (.clock(clock), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_hv), .internal_osc(src_clk[0]),
		.low_speed_osc(src_clk[1]), .high_speed_osc(src_clk[2]), .external_clk(src_clk[3]),
		.count_value(count_hv), .count_tick(), .compare_counter_sel(), .compare_buffer_on(),
		.multi_compare_mode(multi_hv), .half_rate_mode(half_hv), .counter_running());
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr16(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr16
	// Read data is looked at only in the cycle after the strobe
	task rd16(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clock);
		addr <= a; rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd16
	// Write then read with no gap, so the read meets a pending counter reset
	task wr_rd16(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp,
		input logic [15:0] exp_hv);
		@(posedge clock);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0; rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, exp);
		chk(rdata_hv, exp_hv);
	endtask : wr_rd16
	// Period of eight clocks keeps sources well under half the clock rate
	task pulse(input logic [1:0] s, input int k);
		repeat (k) begin
			repeat (4) @(posedge clock);
			src_clk[s] <= 1'b1;
			repeat (4) @(posedge clock);
			src_clk[s] <= 1'b0;
		end
	endtask : pulse
	// Gate off clears the prescaler so every case starts aligned
	task run_case(input logic [7:0] c, input logic [15:0] ctl, input int k,
		input logic [15:0] exp);
		wr16(CLK, 16'h0000);
		wr16(CTL, 16'h0002);
		wr16(CLK, {8'h00, c});
		wr16(CTL, ctl);
		pulse(c[3:2], k);
		repeat (8) @(posedge clock);
		rd16(TC, exp);
		chk(count_value, exp);
	endtask : run_case
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	// Whole run is well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		rd16(CTL, 16'h0000);
		rd16(TC, 16'h0000);
		rd16(CLK, 16'h0000);
		rd16(16'h5404, 16'h0000);
		$display("reset values done");
		wr16(CLK, 16'h00a6);
		rd16(CLK, 16'h00a6);
		chk(rdata_hv, 16'h00a4);
		chk({15'h0000, multi_hv}, 16'h0000);
		wr16(CTL, 16'hfffc);
		rd16(CTL, 16'h003c);
		chk(rdata_hv, 16'h007c);
		chk({15'h0000, half_hv}, 16'h0001);
		chk({13'h0000, sel, buf_on}, 16'h0007);
		chk({15'h0000, multi}, 16'h0001);
		wr16(TC, 16'h1234);
		rd16(TC, 16'h0000);
		$display("register access done");
		run_case(8'h01, 16'h0001, 5, 16'h0005);
		chk({15'h0000, running}, 16'h0001);
		wr_rd16(CTL, 16'h0002, 16'h0000, 16'h0002);
		rd16(TC, 16'h0000);
		rd16(CTL, 16'h0000);
		run_case(8'h05, 16'h0001, 5, 16'h0005);
		run_case(8'h09, 16'h0001, 5, 16'h0005);
		run_case(8'h0d, 16'h0001, 5, 16'h0005);
		run_case(8'h21, 16'h0001, 8, 16'h0002);
		run_case(8'hf1, 16'h0001, 4, 16'h0000);
		run_case(8'h95, 16'h0001, 4, 16'h0000);
		run_case(8'h01, 16'h0041, 6, 16'h0006);
		chk(count_hv, 16'h0003);
		run_case(8'h00, 16'h0001, 5, 16'h0000);
		run_case(8'h01, 16'h0000, 5, 16'h0000);
		run_case(8'h01, 16'h0005, 5, 16'h0005);
		$display("counting done");
		summarize();
	end
endmodule : ptc_core_test
bind ptc_core ptc_core_chk #(.CHANNEL(CHANNEL), .HALF_VARIANT(HALF_VARIANT)) chk (
	.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .count_value(count_value), .count_tick(count_tick),
	.compare_counter_sel(compare_counter_sel), .compare_buffer_on(compare_buffer_on),
	.multi_compare_mode(multi_compare_mode), .half_rate_mode(half_rate_mode),
	.counter_running(counter_running));
